/* File: logic/ccdfe_top.sv */
// CCD front end and converter sequencing with AXI4-Lite control
// Summary of operation
// - Front end runs when its sleep input is low, standby when high.
// - Converter runs when its sleep input is low, standby when high.
// - Data outputs driven while active-low enable low, released while high.
// - Each result is a 10-bit parallel word.
// - Output word appears 2.5 clocks after its sample; capture must compensate.
// - Calibration starts only with reset high and converter sleep low.
// - Calibration lasts 16 times 16384 clock periods.
// - Toggling converter sleep or reset re-runs full calibration.
`default_nettype none
module ccdfe_top
	import ccdfe_pkg::*;
#(
	parameter int DATA_WIDTH = CCDFE_DATA_WIDTH,
	parameter int CAL_CYCLES = CCDFE_CAL_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	// Sensor timing pulses from the timing generator
	input wire logic reset_level_sample,
	input wire logic video_level_sample,
	input wire logic input_coupling_clamp,
	input wire logic optical_black_clamp,
	input wire logic blanking_hold,
	input wire logic converter_sample_pulse,
	// Digitised analog level from the front end model
	input wire logic [DATA_WIDTH-1:0] analog_code,
	// Pin-level sleep and enable controls, ORed with software controls
	input wire logic frontend_sleep,
	input wire logic converter_sleep,
	input wire logic output_enable_n,
	// Converter data pins
	output logic [DATA_WIDTH-1:0] data_out,
	output logic [DATA_WIDTH-1:0] data_oe,
	output logic frontend_active,
	output logic cal_busy,
	output logic cal_done,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [2:0] ctrl;
	logic fe_sleep_eff;
	logic conv_sleep_eff;
	logic oe_n_eff;
	logic [DATA_WIDTH-1:0] cds_level;
	logic [DATA_WIDTH-1:0] black_ref;
	logic [DATA_WIDTH-1:0] frontend_level;
	logic [DATA_WIDTH-1:0] held_sample;
	logic [DATA_WIDTH-1:0] pipe_stage;
	logic [DATA_WIDTH-1:0] result;
	logic [DATA_WIDTH-1:0] next_level;
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Effective controls: pin or software bit may force sleep or release
	assign fe_sleep_eff = frontend_sleep | ctrl[CCDFE_CTRL_FE_SLEEP_BIT];
	assign conv_sleep_eff = converter_sleep | ctrl[CCDFE_CTRL_CONV_SLEEP_BIT];
	assign oe_n_eff = output_enable_n | ctrl[CCDFE_CTRL_OE_N_BIT];
	assign frontend_active = !fe_sleep_eff;

	// Difference of the two correlated samples, clamped at zero
	function automatic logic [DATA_WIDTH-1:0] sat_sub(
		input logic [DATA_WIDTH-1:0] a,
		input logic [DATA_WIDTH-1:0] b
	);
		sat_sub = (a > b) ? a - b : '0;
	endfunction

	// Correlated double sampling; the CDS level holds its value in standby
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cds_level <= CCDFE_DATA_RESET;
		end else if (!fe_sleep_eff) begin
			if (reset_level_sample) begin
				cds_level <= analog_code;
			end else if (video_level_sample) begin
				cds_level <= sat_sub(analog_code, cds_level);
			end
		end
	end

	// Black reference is captured while the optical black clamp is high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			black_ref <= CCDFE_DATA_RESET;
		end else if (!fe_sleep_eff && optical_black_clamp) begin
			black_ref <= cds_level;
		end
	end

	// Clamp and blanking force black; active-low blanking holds black level
	always_comb begin
		next_level = sat_sub(cds_level, black_ref);
		if (input_coupling_clamp || !blanking_hold) begin
			next_level = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || fe_sleep_eff) begin
			frontend_level <= CCDFE_DATA_RESET;
		end else begin
			frontend_level <= next_level;
		end
	end

	// Converter samples only on its pulse, and stays frozen in standby
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_sample <= CCDFE_DATA_RESET;
			pipe_stage <= CCDFE_DATA_RESET;
			result <= CCDFE_DATA_RESET;
		end else if (!conv_sleep_eff) begin
			if (converter_sample_pulse) begin
				held_sample <= frontend_level;
			end
			pipe_stage <= held_sample;
			result <= pipe_stage;
		end
	end

	// Data pins: drive only with enable low; a wide enable keeps it per-bit
	assign data_out = result;
	assign data_oe = oe_n_eff ? '0 : '1;

	ccdfe_calib #(
		.CAL_CYCLES(CAL_CYCLES)
	) u_calib (
		.aclk(aclk),
		.aresetn(aresetn),
		.conv_sleep(conv_sleep_eff),
		.cal_busy(cal_busy),
		.cal_done(cal_done)
	);

	// AXI4-Lite write: address and data taken in either order, then response
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (aw_held && w_held) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Register update and write response; only the control word is writable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CCDFE_CTRL_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CCDFE_RESP_OKAY;
		end else begin
			if (aw_held && w_held) begin
				s_axi_bvalid <= 1'b1;
				if (aw_addr[11:2] == CCDFE_CTRL_OFFSET[11:2]) begin
					if (w_strb[0]) begin
						ctrl <= w_data[2:0];
					end
					s_axi_bresp <= CCDFE_RESP_OKAY;
				end else if (aw_addr[11:2] == CCDFE_STATUS_OFFSET[11:2] ||
						aw_addr[11:2] == CCDFE_DATA_OFFSET[11:2]) begin
					s_axi_bresp <= CCDFE_RESP_OKAY;
				end else begin
					s_axi_bresp <= CCDFE_RESP_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one read at a time, answered the cycle after acceptance
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= CCDFE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= CCDFE_RESP_OKAY;
			case (s_axi_araddr[11:2])
				CCDFE_CTRL_OFFSET[11:2]: begin
					s_axi_rdata <= {29'h0, ctrl};
				end
				CCDFE_STATUS_OFFSET[11:2]: begin
					s_axi_rdata <= {28'h0, !conv_sleep_eff, !fe_sleep_eff, cal_done, cal_busy};
				end
				CCDFE_DATA_OFFSET[11:2]: begin
					s_axi_rdata <= 32'(result);
				end
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= CCDFE_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks on the data path and calibration gating
	AST_FE_SLEEP_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(fe_sleep_eff) |-> frontend_level == '0)
		else $error("Front end level not cleared in standby");
	AST_CONV_FROZEN: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_sleep_eff && $past(conv_sleep_eff) |=> $stable(result))
		else $error("Converter result changed in standby");
	AST_OE_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
		(data_oe == '0) == oe_n_eff)
		else $error("Data enable does not follow active-low enable");
	AST_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn)
		!conv_sleep_eff [*3] |-> result == $past(held_sample, 2))
		else $error("Output latency is not two whole cycles");
	AST_SAMPLE_ONLY_ON_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
		!$past(converter_sample_pulse) && $past(aresetn) |-> $stable(held_sample))
		else $error("Sample taken without sample pulse");
	AST_BLANK_BLACK: assert property (@(posedge aclk) disable iff (!aresetn)
		!blanking_hold && !fe_sleep_eff |=> frontend_level == '0)
		else $error("Blanking did not hold black level");
	AST_CLAMP_BLACK: assert property (@(posedge aclk) disable iff (!aresetn)
		input_coupling_clamp |=> frontend_level == '0)
		else $error("Coupling clamp did not force black");
	AST_OB_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
		optical_black_clamp && !fe_sleep_eff |=> black_ref == $past(cds_level))
		else $error("Black reference not captured");
	AST_CAL_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_sleep_eff |=> !cal_busy && !cal_done)
		else $error("Calibration not restarted by converter sleep");
	AST_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && $past(s_axi_araddr[11:2]) == CCDFE_DATA_OFFSET[11:2]
		&& $rose(s_axi_rvalid) |-> s_axi_rdata == 32'($past(result)))
		else $error("Data read does not match the result word");
endmodule
`default_nettype wire

/* File: logic/ccdfe_pkg.sv */
// Package of constants for the CCD front end and converter sequencing block
`default_nettype none
package ccdfe_pkg;
	localparam int CCDFE_DATA_WIDTH = 10;
	localparam int CCDFE_CAL_MULT = 16;
	localparam int CCDFE_CAL_BASE = 16384;
	localparam int CCDFE_CAL_CYCLES = CCDFE_CAL_MULT * CCDFE_CAL_BASE;
	localparam int CCDFE_CAL_WIDTH = 19;
	// Whole-cycle part of the 2.5 clock output latency; the half cycle is output delay
	localparam int CCDFE_LATENCY_STAGES = 2;
	localparam logic [9:0] CCDFE_DATA_RESET = 10'h000;
	// AXI4-Lite map
	localparam logic [11:0] CCDFE_CTRL_OFFSET = 12'h000;
	localparam logic [11:0] CCDFE_STATUS_OFFSET = 12'h004;
	localparam logic [11:0] CCDFE_DATA_OFFSET = 12'h008;
	localparam int CCDFE_CTRL_FE_SLEEP_BIT = 0;
	localparam int CCDFE_CTRL_CONV_SLEEP_BIT = 1;
	localparam int CCDFE_CTRL_OE_N_BIT = 2;
	localparam logic [2:0] CCDFE_CTRL_RESET = 3'h0;
	localparam int CCDFE_STATUS_CAL_BUSY_BIT = 0;
	localparam int CCDFE_STATUS_CAL_DONE_BIT = 1;
	localparam int CCDFE_STATUS_FE_ACTIVE_BIT = 2;
	localparam int CCDFE_STATUS_CONV_ACTIVE_BIT = 3;
	localparam logic [1:0] CCDFE_RESP_OKAY = 2'h0;
	localparam logic [1:0] CCDFE_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		CCDFE_CAL_IDLE = 2'b00,
		CCDFE_CAL_RUN = 2'b01,
		CCDFE_CAL_DONE = 2'b10
	} ccdfe_cal_state_type;
endpackage
`default_nettype wire

/* File: logic/ccdfe_calib.sv */
// Start-up calibration sequencer for the converter
`default_nettype none
module ccdfe_calib
	import ccdfe_pkg::*;
#(
	parameter int CAL_CYCLES = CCDFE_CAL_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic conv_sleep,
	output logic cal_busy,
	output logic cal_done
);
	ccdfe_cal_state_type state;
	logic [CCDFE_CAL_WIDTH-1:0] count;
	localparam logic [CCDFE_CAL_WIDTH-1:0] LAST = CCDFE_CAL_WIDTH'(CAL_CYCLES - 1);

	// Sleep or reset sends the sequencer back to idle, so release re-runs it
	always_ff @(posedge aclk) begin
		if (!aresetn || conv_sleep) begin
			state <= CCDFE_CAL_IDLE;
			count <= '0;
		end else begin
			case (state)
				CCDFE_CAL_IDLE: begin
					state <= CCDFE_CAL_RUN;
					count <= '0;
				end
				CCDFE_CAL_RUN: begin
					if (count == LAST) begin
						state <= CCDFE_CAL_DONE;
					end
					count <= count + 1'b1;
				end
				CCDFE_CAL_DONE: begin
					state <= CCDFE_CAL_DONE;
				end
				default: begin
					state <= CCDFE_CAL_IDLE;
				end
			endcase
		end
	end

	assign cal_busy = (state == CCDFE_CAL_RUN);
	assign cal_done = (state == CCDFE_CAL_DONE);

	// Busy lasts exactly CAL_CYCLES cycles: done may follow only the last count
	AST_CAL_LENGTH: assert property (@(posedge aclk) disable iff (!aresetn || conv_sleep)
		$rose(cal_done) |-> $past(count) == LAST)
		else $error("Calibration ended at wrong count");
	AST_CAL_START: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_busy |-> !$past(conv_sleep))
		else $error("Calibration ran during converter sleep");
endmodule
`default_nettype wire

/* File: dv/ccdfe_timing_model.sv */
// Timing generator model driving the front end sampling, clamp and conversion strobes
`default_nettype none
module ccdfe_timing_model
	import ccdfe_pkg::*;
(
	input wire logic aclk,
	output logic reset_level_sample,
	output logic video_level_sample,
	output logic input_coupling_clamp,
	output logic optical_black_clamp,
	output logic blanking_hold,
	output logic converter_sample_pulse,
	output logic [CCDFE_DATA_WIDTH-1:0] analog_code
);
	timeunit 1ns;
	timeprecision 100ps;
	// Strobes idle low, blanking hold idle high
	initial begin
		{reset_level_sample, video_level_sample, input_coupling_clamp} = '0;
		{optical_black_clamp, converter_sample_pulse, analog_code} = '0;
		blanking_hold = 1'b1;
	end
	// Dummy pixels clamp the input, then a zero pixel sets the black reference
	task automatic line_start();
		@(posedge aclk);
		analog_code <= 10'h000;
		input_coupling_clamp <= 1'b1;
		{reset_level_sample, video_level_sample} <= 2'h3;
		@(posedge aclk);
		{input_coupling_clamp, reset_level_sample, video_level_sample} <= 3'h0;
		@(posedge aclk);
		optical_black_clamp <= 1'b1;
		@(posedge aclk);
		optical_black_clamp <= 1'b0;
	endtask
	// One pixel: reset level, video level, settle, then one conversion strobe
	task automatic pixel(input logic [9:0] level);
		@(posedge aclk);
		analog_code <= 10'h000;
		reset_level_sample <= 1'b1;
		@(posedge aclk);
		reset_level_sample <= 1'b0;
		analog_code <= level;
		video_level_sample <= 1'b1;
		@(posedge aclk);
		video_level_sample <= 1'b0;
		repeat (3) @(posedge aclk); // Filtered level must settle first
		converter_sample_pulse <= 1'b1;
		@(posedge aclk);
		converter_sample_pulse <= 1'b0;
		analog_code <= ~level; // Input wanders so a stale hold shows up
	endtask
	// Blanking hold is active low for the whole blanking period
	task automatic blank(input logic on);
		@(posedge aclk);
		blanking_hold <= ~on;
	endtask
endmodule
`default_nettype wire

/* File: dv/ccdfe_top_tb.sv */
// Self-checking bench for the CCD front end sequencing block
`default_nettype none
module ccdfe_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ccdfe_pkg::*;
	localparam int CAL = 16;
	logic aclk, aresetn, frontend_sleep, converter_sleep, output_enable_n;
	logic reset_level_sample, video_level_sample, input_coupling_clamp, optical_black_clamp;
	logic blanking_hold, converter_sample_pulse, frontend_active, cal_busy, cal_done;
	logic [9:0] analog_code, data_out, data_oe;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int errors, compares, cycles;
	// Calibration shortened so every restart stays cheap
	ccdfe_top #(.CAL_CYCLES(CAL)) u_dut (
		.aclk, .aresetn, .reset_level_sample, .video_level_sample, .input_coupling_clamp,
		.optical_black_clamp, .blanking_hold, .converter_sample_pulse, .analog_code,
		.frontend_sleep, .converter_sleep, .output_enable_n, .data_out, .data_oe,
		.frontend_active, .cal_busy, .cal_done, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	ccdfe_timing_model u_tgen (
		.aclk, .reset_level_sample, .video_level_sample, .input_coupling_clamp,
		.optical_black_clamp, .blanking_hold, .converter_sample_pulse, .analog_code
	);
	// Clock at 250 MHz
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic tick();
		@(posedge aclk);
		#1;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Write with both channels offered together, each released when taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	// Read; data is only judged when the access is expected to succeed
	task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
		if (er == CCDFE_RESP_OKAY) check("rdata", s_axi_rdata, ed);
	endtask
	// Busy must rise promptly, last exactly the calibration count, then report done
	task automatic cal_run();
		int n;
		n = 0;
		#1; // Step off the edge so a start launched on it is counted
		for (int i = 0; i < 4 && cal_busy !== 1'b1; i++) tick();
		while (cal_busy === 1'b1 && n < 40) begin
			n++;
			tick();
		end
		check("cal_len", n, CAL);
		check("cal_done", cal_done, 1'b1);
	endtask
	// Register map, unmapped place and read-only status
	task automatic t_regs();
		axi_rd(CCDFE_CTRL_OFFSET, 32'h0000_0000, CCDFE_RESP_OKAY);
		axi_rd(CCDFE_STATUS_OFFSET, 32'h0000_000e, CCDFE_RESP_OKAY);
		axi_wr(CCDFE_STATUS_OFFSET, 32'h0000_0000, 4'hf, CCDFE_RESP_OKAY);
		axi_rd(CCDFE_STATUS_OFFSET, 32'h0000_000e, CCDFE_RESP_OKAY);
		axi_rd(12'h80c, 32'h0000_0000, CCDFE_RESP_SLVERR);
		axi_wr(12'hffc, 32'h0000_0007, 4'hf, CCDFE_RESP_SLVERR);
	endtask
	// Words are taken only after calibration, and paired two whole clocks after the sample strobe
	task automatic t_data();
		check("cal_ready", cal_done, 1'b1);
		u_tgen.line_start();
		u_tgen.pixel(10'h2a5);
		tick();
		check("lat_early", data_out, 10'h000);
		tick();
		check("lat_word", data_out, 10'h2a5);
		u_tgen.pixel(10'h3ff);
		tick();
		check("b2b_early", data_out, 10'h2a5);
		tick();
		check("b2b_word", data_out, 10'h3ff);
		axi_rd(CCDFE_DATA_OFFSET, 32'h0000_03ff, CCDFE_RESP_OKAY);
	endtask
	// Converter standby freezes output and holds calibration off by pin; by register only calibration off is checked
	task automatic t_conv_sleep();
		@(posedge aclk);
		converter_sleep <= 1'b1;
		u_tgen.pixel(10'h0f0);
		repeat (2) tick();
		check("sleep_hold", data_out, 10'h3ff);
		check("sleep_cal", cal_busy, 1'b0);
		check("sleep_done", cal_done, 1'b0);
		@(posedge aclk);
		converter_sleep <= 1'b0;
		cal_run();
		axi_wr(CCDFE_CTRL_OFFSET, 32'h0000_0002, 4'h1, CCDFE_RESP_OKAY);
		repeat (3) tick();
		check("reg_sleep_cal", cal_busy, 1'b0);
		check("reg_sleep_done", cal_done, 1'b0);
		axi_wr(CCDFE_CTRL_OFFSET, 32'h0000_0000, 4'h1, CCDFE_RESP_OKAY);
		cal_run();
	endtask
	// Blanking hold low forces a black word
	task automatic t_blank();
		u_tgen.blank(1'b1);
		u_tgen.pixel(10'h155);
		u_tgen.blank(1'b0);
		tick();
		check("blank_word", data_out, 10'h000);
	endtask
	// Output enable and front end standby, by pin and by register
	task automatic t_pins();
		@(posedge aclk);
		{output_enable_n, frontend_sleep} <= 2'h3;
		tick();
		check("oe_pin", data_oe, 10'h000);
		check("fe_pin", frontend_active, 1'b0);
		@(posedge aclk);
		{output_enable_n, frontend_sleep} <= 2'h0;
		tick();
		check("oe_pin_low", data_oe, 10'h3ff);
		check("fe_pin_low", frontend_active, 1'b1);
		axi_wr(CCDFE_CTRL_OFFSET, 32'h0000_0005, 4'h1, CCDFE_RESP_OKAY);
		axi_wr(CCDFE_CTRL_OFFSET, 32'h0000_0000, 4'h0, CCDFE_RESP_OKAY);
		axi_rd(CCDFE_CTRL_OFFSET, 32'h0000_0005, CCDFE_RESP_OKAY);
		tick();
		check("oe_reg", data_oe, 10'h000);
		check("fe_reg", frontend_active, 1'b0);
		axi_wr(CCDFE_CTRL_OFFSET, 32'h0000_0000, 4'h1, CCDFE_RESP_OKAY);
		tick();
		check("oe_reg_low", data_oe, 10'h3ff);
	endtask
	// Reset re-runs calibration, but only once converter standby is left
	task automatic t_reset();
		u_tgen.pixel(10'h1c3);
		repeat (2) tick();
		check("pre_rst_word", data_out, 10'h1c3);
		@(posedge aclk);
		{aresetn, converter_sleep} <= 2'h1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) tick();
		check("rst_word", data_out, 10'h000);
		check("rst_cal", cal_busy, 1'b0);
		check("rst_done", cal_done, 1'b0);
		@(posedge aclk);
		converter_sleep <= 1'b0;
		cal_run();
	endtask
	task automatic complete_run();
		$display("Compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Watchdog: the whole run needs well under a thousand cycles
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			complete_run();
		end
	end
	// Main sequence
	initial begin
		{aresetn, frontend_sleep, converter_sleep, output_enable_n} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		#1; // Still the release cycle: calibration must not have begun
		check("early_cal", cal_busy, 1'b0);
		check("rst_oe", data_oe, 10'h3ff);
		cal_run();
		t_regs();
		t_data();
		t_conv_sleep();
		t_blank();
		t_pins();
		t_reset();
		complete_run();
	end
endmodule
`default_nettype wire
